//--- hdl/seq_pkg.sv
// Shared constants and types for the byte output sequencer and its capture end.
package seq_pkg;
  // Core clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 8000;
  // Conversion time in nanoseconds, as printed (1.5 us).
  localparam int CONV_TIME_NS = 1500;
  // Longest time, rounded down to whole cycles.
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Internal conversion clock divider: one enable pulse every N core cycles.
  localparam int CONV_DIV = 4;
  // Width of a strobe phase, in conversion clock ticks.
  localparam int STROBE_TICKS = 2;
  // Result width and byte width.
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  // Bit position inside a result byte that separates over and under range.
  localparam int RANGE_BIT = 7;
  // Reset values.
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Device sequencer states, Gray coded from idle to the second phase; the return to idle flips two bits.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONV = 3'b001,
    ST_LOAD = 3'b011,
    ST_FIRST = 3'b010,
    ST_SECOND = 3'b110
  } seq_state_t;
endpackage : seq_pkg

//--- hdl/seq_if.sv
// Interface joining the converter sequencer and the external capture logic.
`timescale 1ns/1ps
interface seq_if;
  import seq_pkg::*;
  logic convert;
  logic hold;
  logic byte_sel;
  logic strobe;
  logic range_flag;
  logic [BYTE_W-1:0] data;
  modport dev (
    input convert,
    input byte_sel,
    output hold,
    output strobe,
    output range_flag,
    output data
  );
  modport cap (
    output convert,
    output byte_sel,
    input hold,
    input strobe,
    input range_flag,
    input data
  );
endinterface : seq_if

//--- hdl/adc_byte_output_sequencer.sv
// Converter end: conversion sequencing and byte-serial result delivery.
`timescale 1ns/1ps
// How it works
// - Rising convert edge starts a conversion.
// - Hold output rises on the trigger edge.
// - Hold falls after the conversion time.
// - Conversion clock runs until bytes delivered.
// - Result sent as two bytes, order selectable.
// - First byte at strobe rise, second at fall.
// - High byte is top eight result bits.
// - Poller waits for strobe fall, selects byte.
// - Poller avoids byte select near trigger.
// - Poll completes before next strobes begin.
// - Range flag valid only with high byte.
// - Range flag is one when clipped.
// - Capture first byte on rise, word on fall.
// - Optional relatch for simultaneous update.
// - Latch range flag with high byte.
// - Split under and over range by bit.
// - Latched flag feeds interrupt or indicator.
// - Triggers before strobe fall are ignored.
// - Saturate sum, keep lower sixteen bits.
module adc_byte_output_sequencer
  import seq_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  seq_if.dev LINK,
  input wire logic [RESULT_W+1:0] SUM_I,
  output logic BUSY_O
);
  seq_state_t state_reg, state_next;
  logic [2:0] conv_sync_reg;
  logic conv_prev_reg;
  logic [2:0] sel_sync_reg;
  logic sel_reg;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_reg;
  logic [$clog2(CONV_DIV)-1:0] div_reg;
  logic [3:0] tick_cnt_reg;
  logic [RESULT_W-1:0] result_reg;
  logic clip_reg;
  logic high_first_reg;
  logic hold_reg;
  logic strobe_reg;
  logic flag_reg;
  logic [BYTE_W-1:0] data_reg;
  logic busy_reg;

  // Input pin stability: a change counts once stages two and three agree.
  wire conv_level = (conv_sync_reg[2] == conv_sync_reg[1]) ?
                    conv_sync_reg[2] : conv_prev_reg;
  wire sel_level = (sel_sync_reg[2] == sel_sync_reg[1]) ?
                   sel_sync_reg[2] : sel_reg;
  wire trig_edge = conv_level & ~conv_prev_reg;
  // Triggers outside idle fall on the floor, capping the rate at one conversion per busy window.
  wire trig_take = trig_edge && (state_reg == ST_IDLE);
  // Internal conversion clock as an enable; only counts while busy.
  wire conv_tick = (div_reg == '0) && (state_reg != ST_IDLE);
  wire conv_done = (conv_cnt_reg == '0);
  wire phase_done = conv_tick &&
                    (tick_cnt_reg == 4'(STROBE_TICKS - 1));
  // The second byte replaces the first at mid phase, so that each strobe
  // edge finds its own byte settled on the lines for half a phase before it;
  // the second byte stays only one cycle past the fall, then idle reloads the first.
  wire swap_byte = (state_reg == ST_FIRST) && conv_tick &&
                   (tick_cnt_reg == '0);

  // Saturating range check on the wide internal sum.
  wire sum_neg = SUM_I[RESULT_W+1];
  wire sum_over = ~sum_neg & SUM_I[RESULT_W];
  wire [RESULT_W-1:0] sat_result = sum_neg ? {RESULT_W{1'b0}} :
                                   sum_over ? {RESULT_W{1'b1}} :
                                   SUM_I[RESULT_W-1:0];
  wire sat_clip = sum_neg | sum_over;

  // Byte selection from the result.
  wire [BYTE_W-1:0] high_byte = result_reg[RESULT_W-1:BYTE_W];
  wire [BYTE_W-1:0] low_byte = result_reg[BYTE_W-1:0];
  // While idle the byte select picks the byte directly for polling.
  wire first_is_high = (state_reg == ST_IDLE) ? sel_reg : high_first_reg;
  wire [BYTE_W-1:0] first_byte = first_is_high ? high_byte : low_byte;
  wire [BYTE_W-1:0] second_byte = first_is_high ? low_byte : high_byte;

  // Next state logic.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (trig_take) state_next = ST_CONV;
      ST_CONV: if (conv_done) state_next = ST_LOAD;
      ST_LOAD: if (phase_done) state_next = ST_FIRST;
      ST_FIRST: if (phase_done) state_next = ST_SECOND;
      ST_SECOND: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Synchronisers for the two pins that come from the far end.
  // Three stages cost four cycles of trigger latency, so the far end must
  // keep its byte select still for that long before it triggers.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      conv_sync_reg <= '0;
      sel_sync_reg <= '0;
      conv_prev_reg <= 1'b0;
      sel_reg <= 1'b0;
    end
    else
    begin
      conv_sync_reg <= {conv_sync_reg[1:0], LINK.convert};
      sel_sync_reg <= {sel_sync_reg[1:0], LINK.byte_sel};
      conv_prev_reg <= conv_level;
      sel_reg <= sel_level;
    end
  end

  // Sequencer state, counters and divider.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= '0;
      div_reg <= '0;
      tick_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      div_reg <= (state_reg == ST_IDLE) ? '0 : div_reg + 1'b1;
      if (trig_take)
        conv_cnt_reg <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
      else if (!conv_done)
        conv_cnt_reg <= conv_cnt_reg - 1'b1;
      if (state_reg != state_next)
        tick_cnt_reg <= '0;
      else if (conv_tick)
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  // Byte order latch at the start of conversion, result capture at its end.
  // The sum is taken once, at the end of conversion, so it may move freely
  // while the bytes of the previous result are still being read.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      result_reg <= RESULT_RST;
      clip_reg <= 1'b0;
      high_first_reg <= 1'b1;
    end
    else
    begin
      if (trig_take)
        high_first_reg <= sel_reg;
      if (state_reg == ST_CONV && conv_done)
      begin
        result_reg <= sat_result;
        clip_reg <= sat_clip;
      end
    end
  end

  // Link outputs, all registered so each edge is clean at the pins.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      hold_reg <= 1'b0;
      strobe_reg <= 1'b0;
      flag_reg <= 1'b0;
      data_reg <= BYTE_RST;
      busy_reg <= 1'b0;
    end
    else
    begin
      // Hold follows the accepted edge at once, drops at the end.
      if (trig_take)
        hold_reg <= 1'b1;
      else if (state_reg == ST_CONV && conv_done)
        hold_reg <= 1'b0;
      // Busy covers the whole window in which a new trigger is ignored.
      busy_reg <= (state_next != ST_IDLE);
      // Strobe rises entering the first phase, falls entering the second.
      strobe_reg <= (state_next == ST_FIRST);
      // The first byte stands from the load phase to mid strobe, the
      // second from mid strobe until the strobe has fallen.
      if (state_next == ST_LOAD || state_next == ST_IDLE)
        data_reg <= first_byte;
      else if (swap_byte)
        data_reg <= second_byte;
      // The flag shows only while the high byte is on the lines.
      if (state_next == ST_LOAD || state_next == ST_IDLE)
        flag_reg <= first_is_high & clip_reg;
      else if (swap_byte)
        flag_reg <= ~first_is_high & clip_reg;
    end
  end

  assign LINK.hold = hold_reg;
  assign LINK.strobe = strobe_reg;
  assign LINK.range_flag = flag_reg;
  assign LINK.data = data_reg;
  assign BUSY_O = busy_reg;
endmodule : adc_byte_output_sequencer

//--- hdl/byte_capture.sv
// Capture end: triggers conversions and assembles bytes into words.
`timescale 1ns/1ps
module byte_capture
  import seq_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  seq_if.cap LINK,
  input wire logic CONVERT_I,
  input wire logic HIGH_FIRST_I,
  output logic [RESULT_W-1:0] WORD_O,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic UNDER_O,
  output logic OVER_O,
  output logic CLIP_O
);
  logic [2:0] strb_sync_reg;
  logic strb_reg;
  logic [BYTE_W-1:0] data_reg;
  logic flag_reg;
  logic [BYTE_W-1:0] data_p0_reg;
  logic [BYTE_W-1:0] data_p1_reg;
  logic flag_p0_reg;
  logic flag_p1_reg;
  logic frame_reg;
  logic [BYTE_W-1:0] first_reg;
  logic first_flag_reg;
  logic [RESULT_W-1:0] word_reg;
  logic under_reg;
  logic over_reg;
  logic clip_reg;
  logic conv_reg;
  logic sel_reg;
  logic word_pend_reg;
  // Two-entry buffer toward the user.
  logic [RESULT_W-1:0] buf_mem [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;

  wire strb_level = (strb_sync_reg[2] == strb_sync_reg[1]) ?
                    strb_sync_reg[2] : strb_reg;
  wire strb_rise = strb_level & ~strb_reg;
  wire strb_fall = ~strb_level & strb_reg;
  wire [RESULT_W-1:0] word_hi_first = {first_reg, data_reg};
  wire [RESULT_W-1:0] word_lo_first = {data_reg, first_reg};
  wire [RESULT_W-1:0] word_now = sel_reg ? word_hi_first : word_lo_first;
  wire flag_now = sel_reg ? first_flag_reg : flag_reg;
  wire buf_full = (count_reg == 2'd2);
  wire buf_empty = (count_reg == 2'd0);
  wire push = word_pend_reg & ~buf_full;
  wire pop = WORD_READY_I & ~buf_empty;
  // Head of the buffer after this edge; a word written into the head slot
  // this very cycle is taken straight from the assembly register.
  wire head_idx = rd_ptr_reg ^ pop;
  wire [RESULT_W-1:0] head_word = (push && (wr_ptr_reg == head_idx)) ?
                                  word_reg : buf_mem[head_idx];

  // Byte select changes only while the device is idle and the last word
  // is assembled, never near a trigger, so no noise couples into the
  // sampling instant and the pairing of bytes stays fixed.
  wire sel_ok = ~LINK.strobe & ~LINK.hold & ~CONVERT_I & ~conv_reg &
                ~frame_reg;

  // Strobe sync; data and flag pass as many stages, so each strobe edge
  // meets the byte that stood beside it on the lines.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      strb_sync_reg <= '0;
      strb_reg <= 1'b0;
      data_p0_reg <= BYTE_RST;
      data_p1_reg <= BYTE_RST;
      data_reg <= BYTE_RST;
      flag_p0_reg <= 1'b0;
      flag_p1_reg <= 1'b0;
      flag_reg <= 1'b0;
      frame_reg <= 1'b0;
      conv_reg <= 1'b0;
      sel_reg <= 1'b1;
    end
    else
    begin
      strb_sync_reg <= {strb_sync_reg[1:0], LINK.strobe};
      strb_reg <= strb_level;
      data_p0_reg <= LINK.data;
      data_p1_reg <= data_p0_reg;
      data_reg <= data_p1_reg;
      flag_p0_reg <= LINK.range_flag;
      flag_p1_reg <= flag_p0_reg;
      flag_reg <= flag_p1_reg;
      // A frame lasts from hold until the word has been assembled.
      if (LINK.hold)
        frame_reg <= 1'b1;
      else if (strb_fall)
        frame_reg <= 1'b0;
      conv_reg <= CONVERT_I;
      if (sel_ok)
        sel_reg <= HIGH_FIRST_I;
    end
  end

  // Word assembly, held until the next falling strobe.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      first_reg <= BYTE_RST;
      first_flag_reg <= 1'b0;
      word_reg <= RESULT_RST;
      under_reg <= 1'b0;
      over_reg <= 1'b0;
      clip_reg <= 1'b0;
      word_pend_reg <= 1'b0;
    end
    else
    begin
      if (strb_rise)
      begin
        first_reg <= data_reg;
        first_flag_reg <= flag_reg;
      end
      if (strb_fall)
      begin
        word_reg <= word_now;
        clip_reg <= flag_now;
        under_reg <= flag_now & ~word_now[BYTE_W+RANGE_BIT];
        over_reg <= flag_now & word_now[BYTE_W+RANGE_BIT];
        word_pend_reg <= 1'b1;
      end
      else if (push)
        word_pend_reg <= 1'b0;
    end
  end

  // Buffer writes a word when room exists; a stall holds it pending until room frees or the next falling strobe overwrites it.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (push)
      buf_mem[wr_ptr_reg] <= word_reg;
  end

  // Output registers mirror buffer head and flags.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      WORD_O <= RESULT_RST;
      WORD_VALID_O <= 1'b0;
      UNDER_O <= 1'b0;
      OVER_O <= 1'b0;
      CLIP_O <= 1'b0;
    end
    else
    begin
      WORD_O <= head_word;
      WORD_VALID_O <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'd0;
      UNDER_O <= under_reg;
      OVER_O <= over_reg;
      CLIP_O <= clip_reg;
    end
  end

  assign LINK.convert = conv_reg;
  assign LINK.byte_sel = sel_reg;
endmodule : byte_capture

//--- tb/seq_asserts.sv
// Checker that watches the link between converter and capture ends.
`timescale 1ns/1ps
module seq_asserts
  import seq_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic convert,
  input wire logic hold,
  input wire logic byte_sel,
  input wire logic strobe,
  input wire logic range_flag,
  input wire logic [BYTE_W-1:0] data
);
  logic busy_reg;
  logic hi_first_reg;
  int hold_cnt_reg;

  default clocking dc @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Follow one conversion from hold rise to strobe fall, since the link
  // itself shows no busy flag.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      busy_reg <= 1'b0;
      hi_first_reg <= 1'b1;
      hold_cnt_reg <= 0;
    end
    else
    begin
      if ($rose(hold))
      begin
        busy_reg <= 1'b1;
        hi_first_reg <= byte_sel;
      end
      else if ($fell(strobe))
        busy_reg <= 1'b0;
      hold_cnt_reg <= hold ? hold_cnt_reg + 1 : 0;
    end
  end

  // One strobe phase lasts eight core cycles.
  sequence burst_s;
    strobe [*8] ##1 !strobe;
  endsequence

  a_hold_rise: assert property (
    $rose(convert) && !busy_reg |-> ##[1:6] $rose(hold))
    else $error("hold did not follow convert");
  a_hold_time: assert property (
    $fell(hold) |-> hold_cnt_reg == CONV_CYCLES)
    else $error("hold width wrong");
  a_strobe_follows: assert property (
    $fell(hold) |-> ##[1:20] $rose(strobe))
    else $error("no strobe after conversion");
  a_strobe_width: assert property (
    $rose(strobe) |-> burst_s)
    else $error("strobe width wrong");
  a_data_steady: assert property (
    ($rose(strobe) || $fell(strobe)) |-> $stable(data))
    else $error("data moved at a strobe edge");
  a_flag_high_byte: assert property (
    (($rose(strobe) && !hi_first_reg) || ($fell(strobe) && hi_first_reg))
    |-> !range_flag)
    else $error("range flag outside high byte");
  a_single_accept: assert property (
    $rose(hold) |-> !busy_reg)
    else $error("convert accepted while busy");
  a_select_idle: assert property (
    $changed(byte_sel) |-> !hold && !strobe)
    else $error("byte select moved during conversion");
endmodule : seq_asserts

//--- tb/testbench.sv
// Self-checking bench joining the converter and capture ends.
`timescale 1ns/1ps
module testbench;
  import seq_pkg::*;
  logic CORE_CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic [RESULT_W+1:0] sum = '0;
  logic convert = 1'b0;
  logic high_first = 1'b1;
  logic ready = 1'b0;
  logic [RESULT_W-1:0] word;
  logic word_valid, under, over, clip, busy;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  seq_if lnk ();
  adc_byte_output_sequencer i_adc_byte_output_sequencer (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .LINK(lnk.dev),
    .SUM_I(sum), .BUSY_O(busy));
  byte_capture i_byte_capture (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .LINK(lnk.cap),
    .CONVERT_I(convert), .HIGH_FIRST_I(high_first), .WORD_O(word),
    .WORD_VALID_O(word_valid), .WORD_READY_I(ready),
    .UNDER_O(under), .OVER_O(over), .CLIP_O(clip));
  seq_asserts i_seq_asserts (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .convert(lnk.convert), .hold(lnk.hold), .byte_sel(lnk.byte_sel),
    .strobe(lnk.strobe), .range_flag(lnk.range_flag), .data(lnk.data));

  // Clock at 125 MHz.
  initial forever #4 CORE_CLK_I = ~CORE_CLK_I;

  task automatic give_verdict;
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // A hang counts as a failure; the whole run needs about 2300 cycles.
  always @(posedge CORE_CLK_I)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Inputs always move 1 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask : step

  function automatic logic [15:0] exp_word(input logic [17:0] s);
    exp_word = s[17] ? 16'h0000 : (s[16] ? 16'hffff : s[15:0]);
  endfunction : exp_word

  task automatic pulse_convert;
    convert = 1'b1;
    step(4);
    convert = 0;
  endtask : pulse_convert

  // Each byte is read at the falling clock edge at which its strobe edge
  // is first seen, so it must already stand on the lines then. The wait
  // before the trigger lets a new byte order reach the converter.
  task automatic convert_once(input logic [17:0] s, input logic hf);
    logic s_prev, done;
    logic [7:0] first_b, second_b;
    logic [15:0] e, hi, lo;
    sum = s;
    high_first = hf;
    step(8);
    pulse_convert();
    done = 1'b0;
    s_prev = lnk.strobe;
    for (int n = 0; n < 400 && !done; n++)
    begin
      @(negedge CORE_CLK_I);
      if (lnk.strobe === 1'b1 && !s_prev)
        first_b = lnk.data;
      if (lnk.strobe === 1'b0 && s_prev)
      begin
        second_b = lnk.data;
        done = 1'b1;
      end
      s_prev = lnk.strobe;
    end
    step(1);
    e = exp_word(s);
    hi = {8'h0, e[15:8]};
    lo = {8'h0, e[7:0]};
    chk("first byte", hf ? hi : lo, {8'h0, first_b});
    chk("second byte", hf ? lo : hi, {8'h0, second_b});
  endtask : convert_once

  task automatic pop_word(output logic [15:0] w);
    for (int n = 0; n < 100 && word_valid !== 1'b1; n++)
      step(1);
    w = (word_valid === 1'b1) ? word : 'x;
    ready = 1'b1;
    step(1);
    ready = 1'b0;
  endtask : pop_word

  task automatic t_order;
    logic [15:0] w;
    convert_once(18'h0a53c, 1'b1);
    pop_word(w);
    chk("word high first", 16'ha53c, w);
    chk("clip in range", 16'h0, {15'h0, clip});
    convert_once(18'h03c5a, 1'b0);
    pop_word(w);
    chk("word low first", 16'h3c5a, w);
  endtask : t_order

  // Overflow and the largest in-range code low byte first, negative high byte first.
  task automatic t_clip;
    logic [17:0] s [3] = '{18'h10000, 18'h21234, 18'h0ffff};
    logic [15:0] w, e;
    logic c;
    for (int i = 0; i < 3; i++)
    begin
      convert_once(s[i], i[0]);
      pop_word(w);
      e = exp_word(s[i]);
      c = s[i][17] | s[i][16];
      chk("saturated word", e, w);
      chk("clip", {15'h0, c}, {15'h0, clip});
      chk("over", {15'h0, c & e[15]}, {15'h0, over});
      chk("under", {15'h0, c & ~e[15]}, {15'h0, under});
    end
  endtask : t_clip

  // A second convert inside the busy window must be dropped.
  task automatic t_rate;
    logic [15:0] w;
    sum = 18'h01357;
    high_first = 1'b1;
    step(3);
    pulse_convert();
    step(40);
    chk("busy in conversion", 16'h1, {15'h0, busy});
    chk("hold in conversion", 16'h1, {15'h0, lnk.hold});
    pulse_convert();
    step(400);
    chk("busy after delivery", 16'h0, {15'h0, busy});
    chk("hold after delivery", 16'h0, {15'h0, lnk.hold});
    pop_word(w);
    chk("kept word", 16'h1357, w);
    step(3);
    chk("no extra word", 16'h0, {15'h0, word_valid});
  endtask : t_rate

  // The reader stalls over two words, then drains them in order.
  task automatic t_stall;
    logic [15:0] w;
    convert_once(18'h00001, 1'b1);
    convert_once(18'h0fffe, 1'b0);
    step(20);
    pop_word(w);
    chk("buffered first", 16'h0001, w);
    pop_word(w);
    chk("buffered second", 16'hfffe, w);
    step(5);
    chk("buffer empty", 16'h0, {15'h0, word_valid});
  endtask : t_stall

  // After the strobe falls the select input picks the byte shown.
  task automatic t_poll;
    logic [15:0] w;
    convert_once(18'h0c3a5, 1'b1);
    high_first = 1'b0;
    step(10);
    chk("polled low", 16'h00a5, {8'h0, lnk.data});
    high_first = 1'b1;
    step(10);
    chk("polled high", 16'h00c3, {8'h0, lnk.data});
    pop_word(w);
    chk("polled word", 16'hc3a5, w);
  endtask : t_poll

  // Reset for six cycles, then run every scenario.
  initial
  begin
    step(6);
    RST_N_I = 1'b1;
    chk("select after reset", 16'h1, {15'h0, lnk.byte_sel});
    step(5);
    t_order();
    t_clip();
    t_rate();
    t_stall();
    t_poll();
    give_verdict();
  end
endmodule : testbench
